// ==== lmc_config.v ====
// local memory configuration register with power-on strap capture
// assumes strap pins come from outside and a simple register port
`include "lmc_map.vh"
module lmc_config #(
  parameter ADDR_W = 24
) (
  // clock and reset
  input  wire              clk,
  input  wire              rst,
  // strap pins
  input  wire [1:0]        memory_size_strap_pins,
  input  wire [1:0]        column_size_strap_pins,
  input  wire              bus_width_strap_pin,
  // setup choice
  input  wire              embedded_sel,
  // register port
  input  wire [ADDR_W-1:0] reg_addr,
  input  wire              reg_wr,
  input  wire              reg_rd,
  input  wire [31:0]       reg_wdata,
  output reg  [31:0]       reg_rdata,
  // decoded configuration
  output reg  [6:0]        mem_size_mb,
  output reg  [10:0]       col_words,
  output reg               bus_is_64,
  output reg  [1:0]        mem_setup,
  output reg  [7:0]        max_clk_mhz
);
  // ***************************************
  // local constants
  // ***************************************
  localparam [ADDR_W-1:0] CTRL_ADDR   = `LMC_CTRL_OFFSET;
  localparam [7:0]        EMB_CLK_MHZ = `LMC_MEM_CLK_MHZ;
  localparam [7:0]        NO_CLK_MHZ  = 8'h00;
  localparam [1:0]        SETUP_EMB32 = 2'h0;
  localparam [1:0]        SETUP_EXT32 = 2'h1;
  localparam [1:0]        SETUP_EXT64 = 2'h2;
  localparam [6:0]        SIZE_16MB   = 7'h10;
  localparam [6:0]        SIZE_32MB   = 7'h20;
  localparam [6:0]        SIZE_64MB   = 7'h40;
  localparam [6:0]        SIZE_8MB    = 7'h08;
  localparam [10:0]       COL_256     = 11'h100;
  localparam [10:0]       COL_512     = 11'h200;
  localparam [10:0]       COL_1024    = 11'h400;

  // ***************************************
  // state and next values
  // ***************************************
  reg  [4:0]  strap_s1_r;
  reg  [4:0]  strap_s2_r;
  reg         rst_d_r;
  reg  [31:0] ctrl_r;
  reg  [31:0] ctrl_nxt;
  reg  [31:0] rdata_nxt;
  reg  [6:0]  size_nxt;
  reg  [10:0] col_nxt;
  reg         wide_nxt;
  reg  [1:0]  setup_nxt;
  reg  [7:0]  clk_mhz_nxt;
  wire        hit;
  wire [1:0]  strap_size;
  wire [1:0]  strap_col;
  wire        strap_wide;
  wire [1:0]  sel_size;
  wire [1:0]  sel_col;
  wire        sel_wide;

  // ***************************************
  // field decoders
  // ***************************************
  // size selector to megabytes
  function [6:0] size_decode;
    input [1:0] sel;
    begin
      case (sel)
        `LMC_SIZE_16MB: size_decode = SIZE_16MB;
        `LMC_SIZE_32MB: size_decode = SIZE_32MB;
        `LMC_SIZE_64MB: size_decode = SIZE_64MB;
        default:        size_decode = SIZE_8MB;
      endcase
    end
  endfunction

  // column selector to words; upper bit alone means 1024
  function [10:0] col_decode;
    input [1:0] sel;
    begin
      if (sel[1])
        col_decode = COL_1024;
      else if (sel[0])
        col_decode = COL_512;
      else
        col_decode = COL_256;
    end
  endfunction

  // memory arrangement from embedded choice and bus width
  function [1:0] setup_decode;
    input emb;
    input wide;
    begin
      if (emb)
        setup_decode = SETUP_EMB32;
      else if (wide)
        setup_decode = SETUP_EXT64;
      else
        setup_decode = SETUP_EXT32;
    end
  endfunction

  // clock ceiling only known for the embedded memory
  function [7:0] clk_decode;
    input emb;
    begin
      if (emb)
        clk_decode = EMB_CLK_MHZ;
      else
        clk_decode = NO_CLK_MHZ;
    end
  endfunction

  // ***************************************
  // field views
  // ***************************************
  assign hit        = (reg_addr == CTRL_ADDR);
  assign strap_wide = strap_s2_r[0];
  assign strap_size = strap_s2_r[2:1];
  assign strap_col  = strap_s2_r[4:3];
  assign sel_size   = ctrl_r[`LMC_SIZE_MSB:`LMC_SIZE_LSB];
  assign sel_col    = ctrl_r[`LMC_COL_MSB:`LMC_COL_LSB];
  assign sel_wide   = ctrl_r[`LMC_WIDTH_BIT];

  // ***************************************
  // strap synchroniser
  // ***************************************
  // two stages, straps are asynchronous board levels
  always @(posedge clk)
  begin
    strap_s1_r <= {column_size_strap_pins, memory_size_strap_pins,
                   bus_width_strap_pin};
    strap_s2_r <= strap_s1_r;
    rst_d_r    <= rst;
  end

  // ***************************************
  // control register
  // ***************************************
  // strap latch in the release cycle wins over a write
  always @*
  begin
    ctrl_nxt = ctrl_r;
    if (rst_d_r)
    begin
      ctrl_nxt[`LMC_SIZE_MSB:`LMC_SIZE_LSB] = strap_size;
      ctrl_nxt[`LMC_COL_MSB:`LMC_COL_LSB]   = strap_col;
      ctrl_nxt[`LMC_WIDTH_BIT]              = strap_wide;
    end
    else if (reg_wr && hit)
    begin
      ctrl_nxt = reg_wdata;
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_r <= `LMC_CTRL_RESET;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ***************************************
  // read data
  // ***************************************
  // holds between reads, unmapped reads give zero
  always @*
  begin
    rdata_nxt = reg_rdata;
    if (reg_rd && hit)
      rdata_nxt = ctrl_r;
    else if (reg_rd)
      rdata_nxt = 32'h0000_0000;
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ***************************************
  // decode
  // ***************************************
  always @*
  begin
    size_nxt    = size_decode(sel_size);
    col_nxt     = col_decode(sel_col);
    wide_nxt    = sel_wide;
    setup_nxt   = setup_decode(embedded_sel, sel_wide);
    clk_mhz_nxt = clk_decode(embedded_sel);
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      mem_size_mb <= SIZE_16MB;
      col_words   <= COL_256;
      bus_is_64   <= 1'b0;
      mem_setup   <= SETUP_EMB32;
      max_clk_mhz <= NO_CLK_MHZ;
    end
    else
    begin
      mem_size_mb <= size_nxt;
      col_words   <= col_nxt;
      bus_is_64   <= wide_nxt;
      mem_setup   <= setup_nxt;
      max_clk_mhz <= clk_mhz_nxt;
    end
  end
endmodule // lmc_config

// ==== lmc_map.vh ====
// constants for the local memory configuration block
// assumes a 32-bit register window addressed by byte offset
`ifndef LMC_MAP_VH
`define LMC_MAP_VH
`define LMC_CTRL_OFFSET   24'h00_0004
`define LMC_SIZE_LSB      12
`define LMC_SIZE_MSB      13
`define LMC_COL_LSB       14
`define LMC_COL_MSB       15
`define LMC_WIDTH_BIT     1
`define LMC_CTRL_RESET    32'h0000_0000
`define LMC_SIZE_16MB     2'h0
`define LMC_SIZE_32MB     2'h1
`define LMC_SIZE_64MB     2'h2
`define LMC_SIZE_8MB      2'h3
`define LMC_MEM_CLK_MHZ   8'hA6
`define LMC_EMB_SIZE_MB   16
`endif

// ==== lmc_straps.sv ====
// strap model: levels during rst, pins toggle after; bench drives rst
module lmc_straps (input wire clk, rst, input wire [4:0] strap_val,
  output logic [1:0] column_size_strap_pins, memory_size_strap_pins,
  output logic bus_width_strap_pin);
  timeunit 1ns; timeprecision 1ns;
  logic [4:0] p = 0;
  assign {column_size_strap_pins, memory_size_strap_pins,
    bus_width_strap_pin} = p;
  always @(posedge clk) p <= rst ? strap_val : ~p;
endmodule // lmc_straps

// ==== lmc_sva.sv ====
// checker on lmc_config outputs; bound below
module lmc_sva (input wire clk, rst, embedded_sel, bus_is_64, reg_rd,
  input wire [1:0] mem_setup, input wire [7:0] max_clk_mhz,
  input wire [23:0] reg_addr, input wire [31:0] reg_rdata,
  input wire [6:0] mem_size_mb, input wire [10:0] col_words);
  timeunit 1ns; timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_emb; embedded_sel[*3] |-> max_clk_mhz == 166 && !mem_setup;
  endproperty
  a_emb: assert property (p_emb) else $error("emb");
  property p_ext; !embedded_sel[*3] |-> mem_setup == bus_is_64 + 1;
  endproperty
  a_ext: assert property (p_ext) else $error("ext");
  property p_rd_size; reg_rd && reg_addr == 4 |=> mem_size_mb ==
    (reg_rdata[13:12] == 3 ? 8 : 16 << reg_rdata[13:12]); endproperty
  a_rd_size: assert property (p_rd_size) else $error("size");
  property p_rd_col; reg_rd && reg_addr == 4 |=> col_words ==
    (reg_rdata[15] ? 1024 : 256 << reg_rdata[14]); endproperty
  a_rd_col: assert property (p_rd_col) else $error("col");
  property p_rd_wide; reg_rd && reg_addr == 4 |=>
    bus_is_64 == reg_rdata[1]; endproperty
  a_rd_wide: assert property (p_rd_wide) else $error("wide");
  property p_rd_void; reg_rd && reg_addr != 4 |=> reg_rdata == 0;
  endproperty
  a_rd_void: assert property (p_rd_void) else $error("void");
  c_e: cover property (embedded_sel[*3]);
  c_x: cover property (!embedded_sel[*3]);
  c_w: cover property (bus_is_64);
endmodule // lmc_sva
bind lmc_config lmc_sva chk_u (.*);

// ==== tb.sv ====
// bench: lmc_config against word c; lmc_straps drives straps
module tb;
  timeunit 1ns; timeprecision 1ns;
  logic clk=0, rst=1, embedded_sel=0, reg_wr=0, reg_rd=0, bus_is_64;
  logic [23:0] reg_addr=0; logic [31:0] reg_wdata=0, reg_rdata, c;
  logic [4:0] strap_val=0; logic [6:0] mem_size_mb; logic [10:0] col_words;
  logic [1:0] mem_setup, memory_size_strap_pins, column_size_strap_pins;
  logic [7:0] max_clk_mhz; logic bus_width_strap_pin;
  int bad_count=0, comparisons=0, cyc=0;
  lmc_config dut_u (.*);
  lmc_straps st_u (.*);
  initial forever #50 clk = ~clk;
  always @(posedge clk) if (++cyc > 900) begin bad_count++; stop_test; end
  task stop_test;
    $display("%0d checks %0d bad", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task cmp(string n, logic [31:0] e, g);
    comparisons++;
    bad_count += e !== g;
    if (e !== g) $display("CHECK FAILED %s %h %h", n, e, g);
  endtask
  task ck(int a, logic [31:0] e);
    @(negedge clk);
    cmp("cfg", {c[13:12] == 3 ? 7'd8 : 7'd16 << c[13:12], c[15] ? 11'd1024 :
      11'd256 << c[14], c[1]}, {mem_size_mb, col_words, bus_is_64});
    cmp("setup", {embedded_sel ? 2'b00 : c[1] ? 2'b10 : 2'b01, embedded_sel ?
      8'd166 : 8'd0}, {mem_setup, max_clk_mhz});
    reg_addr = a; reg_rd = 1; @(negedge clk); reg_rd = 0;
    cmp("rdata", e, reg_rdata);
  endtask
  initial begin
    void'($urandom(58225));
    for (int i = 0; i < 12; i++) begin
      strap_val = {2'($urandom), i[1:0], 1'($urandom)}; rst = 1;
      repeat (5) @(negedge clk); rst = 0;
      c = {strap_val[4:1], 10'h0, strap_val[0], 1'b0};
      @(negedge clk); ck(4, c);
      reg_wdata = $urandom; reg_addr = i[0] ? 4 : 8; reg_wr = 1;
      embedded_sel = $urandom; @(negedge clk); reg_wr = 0;
      if (i[0]) c = reg_wdata;
      repeat (2) @(negedge clk); ck(i[1] ? 4 : 8, i[1] ? c : 0);
    end
    stop_test;
  end
endmodule // tb
